// ### common/sxa_pkg.sv
// package for the subtract/xor/swap alu slice
package sxa_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_HI_LSB = 4;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        SXA_OP_NONE,
        SXA_OP_LITERAL_MINUS_ACC,
        SXA_OP_FILE_MINUS_ACC,
        SXA_OP_ACC_XOR_LITERAL,
        SXA_OP_ACC_XOR_FILE,
        SXA_OP_NIBBLE_EXCHANGE
    } sxa_op_t;

    // one issued operation from the decoder
    typedef struct packed {
        logic valid;
        sxa_op_t op;
        logic [7:0] literal;
        logic [6:0] file_addr;
        logic dest_sel;
        logic [7:0] file_data;
    } sxa_req_t;

    // write-back toward the register file
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } sxa_file_wr_t;

    typedef struct packed {
        logic carry;
        logic nibble_borrow_flag;
        logic zero;
    } sxa_flags_t;

    localparam sxa_flags_t FLAGS_RESET = '0;

endpackage

// ### rtl/sxa_alu.sv
// subtract, xor and nibble-swap alu slice with accumulator and flags
`timescale 1ns/1ps
// Summary of operation
// - literal_minus_acc puts literal minus acc in acc, updates all flags.
// - on subtracts carry is 1 when acc <= operand, nibble flag on 3:0.
// - file_minus_acc takes register (address 0 to 127) minus acc.
// - on register ops dest select 0 writes acc and 1 the register.
// - acc_xor_literal xors acc with the literal into acc, zero only.
// - nibble_exchange swaps the register nibbles and changes no flag.
// - acc_xor_file xors acc with the register by dest select, zero only.
// - nibble_exchange with dest select 1 writes the register, 0 acc.
module sxa_alu
    import sxa_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // operation from decoder, with register read data
    input wire sxa_pkg::sxa_req_t req,
    // results
    output sxa_pkg::sxa_file_wr_t file_wr,
    output logic [7:0] acc,
    output sxa_pkg::sxa_flags_t flags
);
    import sxa_pkg::*;

    // every check below runs on the core clock and sleeps in reset
    default clocking check_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // ****************************************************
    // operand selection and arithmetic
    // ****************************************************
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    sxa_flags_t flags_reg;
    sxa_flags_t flags_next;
    sxa_file_wr_t file_wr_reg;
    sxa_file_wr_t file_wr_next;
    logic [7:0] sub_src;
    logic [8:0] diff;
    logic [4:0] nib_diff;
    logic [7:0] result;
    logic is_sub;
    logic is_xor;
    logic is_file_op;
    logic to_file;

    always_comb begin
        is_sub = req.op == SXA_OP_LITERAL_MINUS_ACC ||
                 req.op == SXA_OP_FILE_MINUS_ACC;
        is_xor = req.op == SXA_OP_ACC_XOR_LITERAL ||
                 req.op == SXA_OP_ACC_XOR_FILE;
        is_file_op = req.op == SXA_OP_FILE_MINUS_ACC ||
                     req.op == SXA_OP_ACC_XOR_FILE ||
                     req.op == SXA_OP_NIBBLE_EXCHANGE;
        to_file = req.valid && is_file_op && req.dest_sel == DEST_FILE;
        sub_src = (req.op == SXA_OP_LITERAL_MINUS_ACC) ? req.literal
                                                       : req.file_data;
        // two's complement: src + ~acc + 1, carry out means no borrow
        diff = {1'b0, sub_src} + {1'b0, ~acc_reg} + 9'h001;
        nib_diff = {1'b0, sub_src[NIB_LO_MSB:0]}
                 + {1'b0, ~acc_reg[NIB_LO_MSB:0]} + 5'h01;
        unique case (req.op)
            SXA_OP_LITERAL_MINUS_ACC: result = diff[7:0];
            SXA_OP_FILE_MINUS_ACC: result = diff[7:0];
            SXA_OP_ACC_XOR_LITERAL: result = acc_reg ^ req.literal;
            SXA_OP_ACC_XOR_FILE: result = acc_reg ^ req.file_data;
            SXA_OP_NIBBLE_EXCHANGE: result = {req.file_data[NIB_LO_MSB:0],
                req.file_data[7:NIB_HI_LSB]};
            default: result = ZERO_BYTE;
        endcase
    end

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        acc_next = acc_reg;
        flags_next = flags_reg;
        file_wr_next = '0;
        if (req.valid && req.op != SXA_OP_NONE) begin
            if (to_file) begin
                file_wr_next.we = 1'b1;
                file_wr_next.addr = req.file_addr;
                file_wr_next.data = result;
            end else begin
                acc_next = result;
            end
            if (is_sub) begin
                flags_next.carry = diff[8];
                flags_next.nibble_borrow_flag = nib_diff[4];
            end
            // nibble exchange leaves every flag alone
            if (is_sub || is_xor) begin
                flags_next.zero = result == ZERO_BYTE;
            end
        end
    end

    // ****************************************************
    // state registers
    // ****************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            acc_reg <= ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // write strobe lasts one cycle per issued operation whose destination is the register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            file_wr_reg <= '0;
        end else begin
            file_wr_reg <= file_wr_next;
        end
    end

    assign acc = acc_reg;
    assign flags = flags_reg;
    assign file_wr = file_wr_reg;

    // ****************************************************
    // checks
    // ****************************************************
    // operation classes that the checks below start from
    sequence sub_issue_s;
        req.valid && is_sub;
    endsequence

    sequence file_issue_s;
        req.valid && is_file_op && req.dest_sel == DEST_FILE;
    endsequence

    // literal ops land here whatever dest select says
    sequence acc_issue_s;
        req.valid && req.op != SXA_OP_NONE && !to_file;
    endsequence

    sequence idle_s;
        !req.valid || req.op == SXA_OP_NONE;
    endsequence

    literal_sub_value_a: assert property (
        req.valid && req.op == SXA_OP_LITERAL_MINUS_ACC
        |=> acc == 8'($past(req.literal) - $past(acc_reg)))
        else $error("literal minus acc wrong");

    sub_carry_a: assert property (
        sub_issue_s |=> flags.carry == ($past(acc_reg) <= $past(sub_src)))
        else $error("subtract carry wrong");

    sub_nibble_a: assert property (
        sub_issue_s |=> flags.nibble_borrow_flag ==
            ($past(acc_reg[3:0]) <= $past(sub_src[3:0])))
        else $error("nibble borrow flag wrong");

    file_sub_value_a: assert property (
        req.valid && req.op == SXA_OP_FILE_MINUS_ACC
            && req.dest_sel == DEST_ACC
        |=> acc == 8'($past(req.file_data) - $past(acc_reg)))
        else $error("file minus acc wrong");

    file_sub_write_a: assert property (
        req.valid && req.op == SXA_OP_FILE_MINUS_ACC
            && req.dest_sel == DEST_FILE
        |=> file_wr.data == 8'($past(req.file_data) - $past(acc_reg)))
        else $error("file minus acc write wrong");

    dest_file_a: assert property (
        file_issue_s |=> file_wr.we && file_wr.addr == $past(req.file_addr)
            && $stable(acc))
        else $error("file destination wrong");

    dest_acc_a: assert property (
        acc_issue_s |=> !file_wr.we)
        else $error("accumulator destination wrote the register");

    // nothing issued must leave every output quiet
    idle_hold_a: assert property (
        idle_s |=> $stable(acc) && $stable(flags) && !file_wr.we)
        else $error("idle cycle changed state");

    xor_literal_value_a: assert property (
        req.valid && req.op == SXA_OP_ACC_XOR_LITERAL
        |=> acc == ($past(acc_reg) ^ $past(req.literal)))
        else $error("xor with literal wrong");

    xor_flags_a: assert property (
        req.valid && is_xor |=> $stable(flags.carry)
            && $stable(flags.nibble_borrow_flag))
        else $error("xor touched carry flags");

    swap_acc_a: assert property (
        req.valid && req.op == SXA_OP_NIBBLE_EXCHANGE
            && req.dest_sel == DEST_ACC
        |=> acc == {$past(req.file_data[3:0]), $past(req.file_data[7:4])}
            && $stable(flags))
        else $error("nibble exchange to acc wrong");

    xor_file_value_a: assert property (
        req.valid && req.op == SXA_OP_ACC_XOR_FILE
            && req.dest_sel == DEST_FILE
        |=> file_wr.data == ($past(acc_reg) ^ $past(req.file_data)))
        else $error("xor to file wrong");

    swap_file_a: assert property (
        req.valid && req.op == SXA_OP_NIBBLE_EXCHANGE
            && req.dest_sel == DEST_FILE
        |=> file_wr.data == {$past(req.file_data[3:0]),
            $past(req.file_data[7:4])} && $stable(flags))
        else $error("nibble exchange to file wrong");

    // judged on what left the block, so a wrong result route shows too
    zero_flag_a: assert property (
        req.valid && (is_sub || is_xor)
        |=> flags.zero == ((file_wr.we ? file_wr.data : acc) == ZERO_BYTE))
        else $error("zero flag wrong");

endmodule

// ### sim/tb_top.sv
// self-checking bench for the subtract/xor/swap alu slice
`timescale 1ns/1ps
module tb_top;
    import sxa_pkg::*;
    typedef struct packed {
        logic [7:0] acc;
        sxa_flags_t flags;
        sxa_file_wr_t wr;
    } sxa_exp_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    sxa_req_t req = '0;
    sxa_file_wr_t file_wr;
    logic [7:0] acc;
    sxa_flags_t flags;
    sxa_exp_t notes[$];
    logic [7:0] m_acc = 8'h00;
    sxa_flags_t m_flags = '0;
    int num_errors = 0;
    int samples_checked = 0;

    sxa_alu dut (.core_clk(core_clk), .reset(reset), .req(req),
        .file_wr(file_wr), .acc(acc), .flags(flags));

    always #10 core_clk = ~core_clk;

    // ********************************************
    // compare tasks and closing
    // ********************************************
    task automatic miss(string what, logic [15:0] e, logic [15:0] s);
        num_errors++;
        $display("ERROR %s expected %h seen %h", what, e, s);
    endtask
    task automatic chk_acc(logic [7:0] e, logic [7:0] s);
        samples_checked++;
        if (s !== e) miss("acc", 16'(e), 16'(s));
    endtask
    task automatic chk_flags(sxa_flags_t e, sxa_flags_t s);
        samples_checked++;
        if (s !== e) miss("flags", 16'(e), 16'(s));
    endtask
    task automatic chk_wr(sxa_file_wr_t e, sxa_file_wr_t s);
        samples_checked++;
        if (s !== e) miss("file_wr", e, s);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ********************************************
    // driver: presents one request and notes its result
    // ********************************************
    task automatic issue(logic v, sxa_op_t op, logic [7:0] k, logic [6:0] a,
            logic d, logic [7:0] f);
        sxa_exp_t e;
        logic [7:0] src;
        logic [7:0] r;
        logic to_reg;
        e = '{acc: m_acc, flags: m_flags, wr: '0};
        src = (op == SXA_OP_FILE_MINUS_ACC) ? f : k;
        to_reg = d && (op inside {SXA_OP_FILE_MINUS_ACC, SXA_OP_ACC_XOR_FILE,
            SXA_OP_NIBBLE_EXCHANGE});
        case (op)
            SXA_OP_LITERAL_MINUS_ACC, SXA_OP_FILE_MINUS_ACC: begin
                r = src - m_acc;
                e.flags.carry = (m_acc <= src);
                e.flags.nibble_borrow_flag =
                    (m_acc[3:0] <= src[3:0]);
            end
            SXA_OP_ACC_XOR_LITERAL: r = m_acc ^ k;
            SXA_OP_ACC_XOR_FILE: r = m_acc ^ f;
            SXA_OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
            default: r = m_acc;
        endcase
        if (!(op inside {SXA_OP_NONE, SXA_OP_NIBBLE_EXCHANGE}))
            e.flags.zero = (r == ZERO_BYTE);
        if (to_reg) e.wr = '{1'b1, a, r};
        else if (op != SXA_OP_NONE) e.acc = r;
        req = '{valid: v, op: op, literal: k, file_addr: a, dest_sel: d,
            file_data: f};
        if (v) begin
            m_acc = e.acc;
            m_flags = e.flags;
            notes.push_back(e);
        end
        @(posedge core_clk);
        #1;
    endtask

    // request held idle for n edges; issue leaves valid up so that
    // back-to-back calls never drive it twice in one step
    task automatic idle(int n);
        req.valid = 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ********************************************
    // monitor: one result per taken request, one cycle later
    // ********************************************
    always @(posedge core_clk) begin
        sxa_exp_t e;
        if (!reset && req.valid) begin
            #2;
            if (notes.size() == 0) miss("note queue", 16'h0001, 16'h0000);
            else begin
                e = notes.pop_front();
                chk_acc(e.acc, acc);
                chk_flags(e.flags, flags);
                chk_wr(e.wr, file_wr);
            end
        end
    end

    initial begin
        #400000;
        num_errors++;
        close_out();
    end

    initial begin
        void'($urandom(91));
        repeat (3) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk_acc(ACC_RESET, acc);
        chk_flags(FLAGS_RESET, flags);
        chk_wr('0, file_wr);
        $display("test reset done");
        // equal operands, then borrow past zero both ways
        issue(1'b1, SXA_OP_LITERAL_MINUS_ACC, 8'h03, 7'h05, 1'b1, 8'h00);
        issue(1'b1, SXA_OP_FILE_MINUS_ACC, 8'h00, 7'h05, 1'b1, 8'h10);
        issue(1'b1, SXA_OP_LITERAL_MINUS_ACC, 8'h03, 7'h00, 1'b0, 8'h00);
        issue(1'b1, SXA_OP_LITERAL_MINUS_ACC, 8'hFF, 7'h00, 1'b0, 8'h00);
        issue(1'b1, SXA_OP_LITERAL_MINUS_ACC, 8'h00, 7'h00, 1'b0, 8'h00);
        issue(1'b1, SXA_OP_FILE_MINUS_ACC, 8'h00, 7'h7F, 1'b0, 8'h10);
        $display("test boundaries done");
        for (int o = 0; o < 6; o++) begin
            for (int d = 0; d < 2; d++) begin
                issue(1'b1, sxa_op_t'(o), 8'($urandom), 7'($urandom),
                    1'(d), 8'($urandom));
            end
        end
        $display("test every op done");
        // reset in mid-run must clear the state an op has just left
        issue(1'b1, SXA_OP_LITERAL_MINUS_ACC, 8'h80, 7'h00, 1'b0, 8'h5A);
        idle(1);
        reset = 1'b1;
        #2;
        chk_acc(ACC_RESET, acc);
        chk_flags(FLAGS_RESET, flags);
        chk_wr('0, file_wr);
        repeat (2) @(posedge core_clk);
        #1;
        reset = 1'b0;
        m_acc = ACC_RESET;
        m_flags = FLAGS_RESET;
        chk_acc(ACC_RESET, acc);
        chk_flags(FLAGS_RESET, flags);
        $display("test mid-run reset done");
        // back to back, with idle and ignored cycles mixed in
        for (int i = 0; i < 400; i++) begin
            issue(1'($urandom_range(3, 0) != 0),
                sxa_op_t'($urandom_range(5, 0)),
                8'($urandom), 7'($urandom), 1'($urandom), 8'($urandom));
        end
        $display("test random stream done");
        idle(3);
        close_out();
    end
endmodule
